// ==== logic/dtd_pkg.sv ====
// constants and carrier types for the dual-tone receiver digital block
package dtd_pkg;
  // tone-group carrier from one frequency meter
  typedef struct packed {
    logic       valid;  // a steady standard tone is present
    logic [1:0] idx;    // which of the four group tones
  } dtd_tone_t;

  // strobed microprocessor port inputs, sampled on clk
  typedef struct packed {
    logic       cs_n;                 // chip select, active low
    logic       rw;                   // 1 read, 0 write
    logic       register_select_bit;  // 0 data, 1 status/control
    logic       bus_strobe_clk;       // bus strobe, may be pulsed only
    logic [3:0] data;                 // data bus input lane
  } dtd_bus_t;

  // nominal tone periods in oscillator ticks (3.5795 MHz / f)
  localparam logic [3:0][15:0] LOW_NOM_TICKS  = {16'h0EDC, 16'h1069, 16'h1229, 16'h1410};
  localparam logic [3:0][15:0] HIGH_NOM_TICKS = {16'h0890, 16'h0977, 16'h0A77, 16'h0B91};
  // no edge after this many ticks means the group has gone quiet
  localparam logic [15:0] LOW_TIMEOUT_TICKS  = 16'h1692;
  localparam logic [15:0] HIGH_TIMEOUT_TICKS = 16'h0D03;
  // tolerance is nominal >> this shift (about 3 percent)
  localparam int TOL_SHIFT = 5;
  // consecutive averaged matches needed before a tone counts
  localparam logic [3:0] AVG_RUN = 4'h4;

  // output latch settling before the delayed steering flag
  localparam int CLK_MHZ    = 125;
  localparam int SETTLE_NS  = 100;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  // control register a fields
  localparam int CA_TX_EN  = 0;
  localparam int CA_CP     = 1;
  localparam int CA_IRQ_EN = 2;
  localparam int CA_SEL_B  = 3;
  // status register fields
  localparam int ST_IRQ    = 0;
  localparam int ST_TX_RDY = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_DSF    = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
endpackage

// ==== logic/dtd_tone_meter.sv ====
// period meter and averaging classifier for one limited tone group
`timescale 1ns/1ps
module dtd_tone_meter
  import dtd_pkg::*;
#(
  parameter logic [3:0][15:0] NOM_TICKS = LOW_NOM_TICKS,
  parameter logic [15:0]      TIMEOUT   = LOW_TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // time base and limited tone
  input  wire logic osc_tick,
  input  wire logic tone_in,
  // result
  output dtd_tone_t tone
);
  logic        tone_prev_reg;  // last comparator level
  logic [15:0] per_cnt_reg;    // ticks since last rising edge
  logic [15:0] last_per_reg;   // previous full period
  logic [1:0]  last_idx_reg;   // class of previous average
  logic        last_hit_reg;   // previous average matched a tone
  logic [3:0]  run_reg;        // consecutive matching averages
  logic        edge_now;
  logic [16:0] sum;
  logic [15:0] avg;
  logic [2:0]  cls;

  // match a period against the four nominals; bit 2 means hit
  function automatic logic [2:0] classify(input logic [15:0] per);
    logic [2:0]  r;
    logic [15:0] tol;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      tol = NOM_TICKS[i] >> TOL_SHIFT;
      if (per >= NOM_TICKS[i] - tol && per <= NOM_TICKS[i] + tol) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  assign edge_now = tone_in & ~tone_prev_reg;
  // average two periods so a single jittered cycle is tolerated
  assign sum = {1'b0, per_cnt_reg} + {1'b0, last_per_reg};
  assign avg = sum[16:1];
  assign cls = classify(avg); // frequency by counting against nominals

  // period counting on oscillator ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      tone_prev_reg <= 1'b0;
      per_cnt_reg   <= 16'h0000;
      last_per_reg  <= 16'h0000;
    end else begin
      tone_prev_reg <= tone_in;
      if (edge_now) begin
        last_per_reg <= per_cnt_reg;
        per_cnt_reg  <= 16'h0000;
      end else if (osc_tick && per_cnt_reg != 16'hFFFF) begin
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
    end
  end

  // run of consistent classes; speech rarely holds one long enough
  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg      <= 4'h0;
      last_idx_reg <= 2'h0;
      last_hit_reg <= 1'b0;
    end else if (per_cnt_reg > TIMEOUT) begin
      run_reg      <= 4'h0;  // quiet group drops at once
      last_hit_reg <= 1'b0;
    end else if (edge_now) begin
      last_idx_reg <= cls[1:0];
      last_hit_reg <= cls[2];
      if (!cls[2]) begin
        run_reg <= 4'h0;
      end else if (last_hit_reg && cls[1:0] == last_idx_reg) begin
        if (run_reg != 4'hF) begin
          run_reg <= run_reg + 4'h1;
        end
      end else begin
        run_reg <= 4'h1;
      end
    end
  end

  // registered result
  always_ff @(posedge clk) begin
    if (rst) begin
      tone <= '0;
    end else begin
      tone.valid <= (run_reg >= AVG_RUN) && (per_cnt_reg <= TIMEOUT);
      tone.idx   <= last_idx_reg;
    end
  end
endmodule

// ==== logic/dtd_receiver.sv ====
// top of the dual-tone receiver: decoder, steering and strobed host port
// How it works
// - count tone periods, accept only standard pairs
// - average successive periods, demand a steady run
// - early steer high while both groups valid, outside call progress mode
// - early steer drops at once on loss
// - register only after external rc confirms duration
// - read drives data bus, write captures it
// - status, two controls, transmit and receive data
// - port works with strobe pulsed only
// - port keeps up with 2 MHz strobe
// - tone period counters timed from crystal oscillator input
// - control bit selects call progress mode
// - steering threshold loads 4-bit digit code
// - guard output high from registration while early steer high
// - settle delay, flag, interrupt pulled low
`timescale 1ns/1ps
module dtd_receiver
  import dtd_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // oscillator pins
  input  wire logic       osc_in,
  output logic            osc_out,
  // limited tone comparators and call progress wave
  input  wire logic       low_tone_in,
  input  wire logic       high_tone_in,
  input  wire logic       cp_wave_in,
  // steering
  output logic            early_steer_out,
  input  wire logic       steer_in,
  output logic            steer_gt_out,
  output logic            steer_gt_oe_n,
  // interrupt or call progress, open drain
  output logic            irq_or_progress_wave_out,
  output logic            irq_or_progress_wave_oe_n,
  // host port
  input  dtd_bus_t        bus,
  output logic [3:0]      data_out,
  output logic            data_oe_n,
  // digit handed to the tone generator
  output logic [3:0]      tx_digit
);
  logic       osc_prev_reg;    // oscillator level one clk ago
  logic       osc_tick;        // one pulse per oscillator cycle
  dtd_tone_t  low_tone;        // low group result
  dtd_tone_t  high_tone;       // high group result
  logic [1:0] pair_lo_reg;     // last valid pair, low index
  logic [1:0] pair_hi_reg;     // last valid pair, high index
  logic       st_prev_reg;     // steering level one clk ago
  logic       regd_reg;        // pair registered, steering still high
  logic [4:0] settle_reg;      // settling counter
  logic       dsf_reg;         // delayed steering flag
  logic [3:0] rx_data_reg;     // receive data register
  logic [3:0] ctrl_a_reg;      // control register a
  logic [3:0] ctrl_b_reg;      // control register b
  logic       sel_b_reg;       // next control write goes to b
  dtd_bus_t   bus_q_reg;       // bus one clk ago
  logic       strobe_fall;
  logic [3:0] status;
  logic       cp_mode;

  // digit code for a low/high index pair
  function automatic logic [3:0] digit_code(input logic [1:0] lo, input logic [1:0] hi);
    case ({lo, hi})
      4'h0: digit_code = 4'h1;
      4'h1: digit_code = 4'h2;
      4'h2: digit_code = 4'h3;
      4'h3: digit_code = 4'hD;
      4'h4: digit_code = 4'h4;
      4'h5: digit_code = 4'h5;
      4'h6: digit_code = 4'h6;
      4'h7: digit_code = 4'hE;
      4'h8: digit_code = 4'h7;
      4'h9: digit_code = 4'h8;
      4'hA: digit_code = 4'h9;
      4'hB: digit_code = 4'hF;
      4'hC: digit_code = 4'hB;
      4'hD: digit_code = 4'hA;
      4'hE: digit_code = 4'hC;
      default: digit_code = 4'h0;
    endcase
  endfunction

  assign osc_tick = osc_in & ~osc_prev_reg; // decoder time base
  assign cp_mode  = ctrl_a_reg[CA_CP];

  // oscillator edge detect and inverting output stage
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_prev_reg <= 1'b0;
      osc_out      <= 1'b1;
    end else begin
      osc_prev_reg <= osc_in;
      osc_out      <= ~osc_in;
    end
  end

  // one meter per tone group
  dtd_tone_meter #(.NOM_TICKS(LOW_NOM_TICKS), .TIMEOUT(LOW_TIMEOUT_TICKS)) u_low (
    .clk      (clk),
    .rst      (rst),
    .osc_tick (osc_tick),
    .tone_in  (low_tone_in),
    .tone     (low_tone)
  );
  dtd_tone_meter #(.NOM_TICKS(HIGH_NOM_TICKS), .TIMEOUT(HIGH_TIMEOUT_TICKS)) u_high (
    .clk      (clk),
    .rst      (rst),
    .osc_tick (osc_tick),
    .tone_in  (high_tone_in),
    .tone     (high_tone)
  );

  // early steering follows the signal condition, no guard
  always_ff @(posedge clk) begin
    if (rst) begin
      early_steer_out <= 1'b0;
      pair_lo_reg     <= 2'h0;
      pair_hi_reg     <= 2'h0;
    end else begin
      // call progress path replaces tone decoding
      early_steer_out <= low_tone.valid & high_tone.valid & ~cp_mode;
      if (low_tone.valid && high_tone.valid) begin
        pair_lo_reg <= low_tone.idx;
        pair_hi_reg <= high_tone.idx;
      end
    end
  end

  // steering threshold registers the pair; rc lives outside
  always_ff @(posedge clk) begin
    if (rst) begin
      st_prev_reg <= 1'b0;
      regd_reg    <= 1'b0;
      rx_data_reg <= 4'h0;
    end else begin
      st_prev_reg <= steer_in;
      if (!steer_in) begin
        regd_reg <= 1'b0; // low steering frees the receiver for a new pair
      end else if (!st_prev_reg) begin
        regd_reg    <= 1'b1;
        rx_data_reg <= digit_code(pair_lo_reg, pair_hi_reg);
      end
    end
  end

  // guard output holds the rc up from registration while early steer stays high
  always_ff @(posedge clk) begin
    if (rst) begin
      steer_gt_out  <= 1'b0;
      steer_gt_oe_n <= 1'b0;
    end else begin
      steer_gt_out  <= (regd_reg | (steer_in & ~st_prev_reg)) & early_steer_out;
      steer_gt_oe_n <= 1'b0; // always driven, the rc resistor isolates it
    end
  end

  // settle delay, then the delayed steering flag
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_reg <= 5'h00;
      dsf_reg    <= 1'b0;
    end else if (!regd_reg) begin
      settle_reg <= 5'h00;
      dsf_reg    <= 1'b0;
    end else if (settle_reg != 5'(SETTLE_CYC)) begin
      settle_reg <= settle_reg + 5'h01;
    end else begin
      dsf_reg <= 1'b1;
    end
  end

  // interrupt pulls low with the flag, or carries the progress wave
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_or_progress_wave_out  <= 1'b0;
      irq_or_progress_wave_oe_n <= 1'b1; // released
    end else begin
      irq_or_progress_wave_out <= 1'b0;
      if (!ctrl_a_reg[CA_IRQ_EN]) begin
        irq_or_progress_wave_oe_n <= 1'b1;
      end else if (cp_mode) begin
        irq_or_progress_wave_oe_n <= cp_wave_in;
      end else begin
        irq_or_progress_wave_oe_n <= ~dsf_reg;
      end
    end
  end

  // port acts on the strobe's falling edge, so a pulsed strobe suffices
  assign strobe_fall = bus_q_reg.bus_strobe_clk & ~bus.bus_strobe_clk;
  assign status = {dsf_reg, dsf_reg, 1'b1, dsf_reg & ctrl_a_reg[CA_IRQ_EN]};

  // bus sample; 2 MHz strobe gives dozens of clk per phase
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_q_reg <= '0;
    end else begin
      bus_q_reg <= bus;
    end
  end

  // register writes on the strobe's falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_a_reg <= CTRL_RST;
      ctrl_b_reg <= CTRL_RST;
      sel_b_reg  <= 1'b0;
      tx_digit   <= 4'h0;
    end else if (strobe_fall && !bus_q_reg.cs_n && !bus_q_reg.rw) begin
      if (!bus_q_reg.register_select_bit) begin
        tx_digit <= bus_q_reg.data;
      end else if (sel_b_reg) begin
        ctrl_b_reg <= bus_q_reg.data;
        sel_b_reg  <= 1'b0;
      end else begin
        ctrl_a_reg <= bus_q_reg.data;
        sel_b_reg  <= bus_q_reg.data[CA_SEL_B];
      end
    end
  end

  // read data driven while selected, reading and strobe high
  always_ff @(posedge clk) begin
    if (rst) begin
      data_out  <= 4'h0;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= ~(~bus.cs_n & bus.rw & bus.bus_strobe_clk);
      data_out  <= bus.register_select_bit ? status : rx_data_reg;
    end
  end
endmodule

// ==== sim/dtd_receiver_chk.sv ====
// pin-level assertions for the dual-tone receiver
`timescale 1ns/1ps
module dtd_receiver_chk
  import dtd_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // steering and interrupt pins
  input wire logic       early_steer_out,
  input wire logic       steer_in,
  input wire logic       steer_gt_out,
  input wire logic       steer_gt_oe_n,
  input wire logic       irq_or_progress_wave_oe_n,
  // host port
  input dtd_bus_t        bus,
  input wire logic       data_oe_n,
  input wire logic [3:0] tx_digit
);
  // one clock domain, so one default clock and disable
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rst_state;
    $fell(rst) |-> !early_steer_out && !steer_gt_out && irq_or_progress_wave_oe_n && data_oe_n;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("outputs not idle after reset");

  property p_gt_drop;
    !early_steer_out |=> !steer_gt_out;
  endproperty
  a_gt_drop: assert property (p_gt_drop)
    else $error("guard drive outlived early steer");

  property p_gt_rise;
    $rose(steer_in) && early_steer_out |-> ##[1:2] steer_gt_out;
  endproperty
  a_gt_rise: assert property (p_gt_rise)
    else $error("guard drive missing after steer rise");

  property p_gt_oe;
    !steer_gt_oe_n;
  endproperty
  a_gt_oe: assert property (p_gt_oe)
    else $error("guard pin not driven");

  property p_rd_drive;
    !bus.cs_n && bus.rw && bus.bus_strobe_clk |=> !data_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read did not drive data bus");

  property p_rd_release;
    bus.cs_n || !bus.rw || !bus.bus_strobe_clk |=> data_oe_n;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("data bus driven outside a read");

  property p_tx_cause;
    !$stable(tx_digit) |-> $past(bus.bus_strobe_clk, 2) && !$past(bus.bus_strobe_clk)
      && tx_digit == $past(bus.data, 2);
  endproperty
  a_tx_cause: assert property (p_tx_cause)
    else $error("transmit digit changed without strobe fall");

  property p_irq_late;
    // in call progress mode the pin follows the wave with steering low, so only flag pulls count
    $fell(irq_or_progress_wave_oe_n) && steer_in |-> $past(steer_in, 12);
  endproperty
  a_irq_late: assert property (p_irq_late)
    else $error("interrupt before settling delay");

  // main scenario reached
  c_es: cover property ($rose(early_steer_out));
endmodule

bind dtd_receiver dtd_receiver_chk u_chk (.clk(clk), .rst(rst), .early_steer_out(early_steer_out),
  .steer_in(steer_in), .steer_gt_out(steer_gt_out), .steer_gt_oe_n(steer_gt_oe_n),
  .irq_or_progress_wave_oe_n(irq_or_progress_wave_oe_n), .bus(bus), .data_oe_n(data_oe_n),
  .tx_digit(tx_digit));

// ==== sim/dtd_rc_model.sv ====
// behavioural rc steering node outside the receiver
`timescale 1ns/1ps
module dtd_rc_model #(
  parameter int RC_CYC = 60  // charge time of the node in cycles
) (
  // clock
  input  wire logic clk,
  // receiver steering pins
  input  wire logic early_steer_out,
  input  wire logic steer_gt_out,
  output logic      steer_in = 1'b0
);
  int cnt = 0;  // cycles early steer has held high
  // node charges while early steer holds; guard keeps it up; drops fast
  always @(posedge clk) begin
    cnt <= early_steer_out ? ((cnt < RC_CYC) ? cnt + 1 : cnt) : 0;
    steer_in <= early_steer_out && (cnt >= RC_CYC || steer_gt_out);
  end
endmodule

// ==== sim/dtd_receiver_tb_top.sv ====
// self-checking bench for the dual-tone receiver
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module dtd_receiver_tb_top
  import dtd_pkg::*;
;
  localparam logic [15:0] LN = LOW_NOM_TICKS[3];   // 941 Hz tone
  localparam logic [15:0] HN = HIGH_NOM_TICKS[2];  // 1477 Hz tone
  logic       clk = 1'b0, rst = 1'b1, osc_in = 1'b0, lo_on = 1'b0, hi_on = 1'b0;
  logic       low_tone_in = 1'b0, high_tone_in = 1'b0;
  dtd_bus_t   bus = '{1'b1, 1'b0, 1'b0, 1'b0, 4'h0};  // host port, idle
  logic       early_steer_out, steer_in, steer_gt_out, steer_gt_oe_n, irq_oe_n, data_oe_n;
  logic [3:0] data_out, tx_digit, rd;
  logic       osc_o, irq_out, op, rd_oe;  // oscillator out, irq value, osc sample, oe seen on read
  logic       cp_wave = 1'b0;             // call progress wave into the receiver
  logic [15:0] lc = 16'h0000, hc = 16'h0000;  // tone phase in ticks
  logic [1:0] oc = 2'h0;                      // oscillator divider
  int         miscompares = 0, checked = 0;

  initial forever #4 clk = ~clk;

  // oscillator of 3 cycles, well below clk/2, and tone dividers
  always @(posedge clk) begin
    oc <= (oc == 2'h2) ? 2'h0 : oc + 2'h1;
    osc_in <= (oc == 2'h0);
    if (oc == 2'h0) begin
      lc <= (lc == LN - 16'h0001) ? 16'h0000 : lc + 16'h0001;
      hc <= (hc == HN - 16'h0001) ? 16'h0000 : hc + 16'h0001;
    end
    low_tone_in <= lo_on && (lc < LN / 2);
    high_tone_in <= hi_on && (hc < HN / 2);
  end

  dtd_receiver uut (.clk(clk), .rst(rst), .osc_in(osc_in), .osc_out(osc_o), .low_tone_in(low_tone_in),
    .high_tone_in(high_tone_in), .cp_wave_in(cp_wave), .early_steer_out(early_steer_out),
    .steer_in(steer_in), .steer_gt_out(steer_gt_out), .steer_gt_oe_n(steer_gt_oe_n),
    .irq_or_progress_wave_out(irq_out), .irq_or_progress_wave_oe_n(irq_oe_n), .bus(bus),
    .data_out(data_out), .data_oe_n(data_oe_n), .tx_digit(tx_digit));
  dtd_rc_model rc (.clk(clk), .early_steer_out(early_steer_out), .steer_gt_out(steer_gt_out),
    .steer_in(steer_in));

  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // strobed access: select held over high and low strobe phases
  task automatic xfer(input logic cs_n, input logic rs, input logic rw, input logic [3:0] d);
    @(posedge clk);
    bus <= '{cs_n, rw, rs, 1'b1, d};
    repeat (3) @(posedge clk);
    rd = data_out;
    rd_oe = data_oe_n;  // drive state while the strobe is still high
    bus.bus_strobe_clk <= 1'b0;
    repeat (3) @(posedge clk);
    bus.cs_n <= 1'b1;
  endtask

  // bounded wait on early steer (0) or steering node (1)
  task automatic wait_sig(input int which, input logic lvl, input int lim);
    int n;
    n = 0;
    while (((which == 0) ? early_steer_out : steer_in) !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      $display("BAD wait_sig %0d exp %b got timeout", which, lvl);
      report_and_stop();
    end
  endtask

  task automatic t_reset;
    `CHK("early_steer", 1'b0, early_steer_out)
    `CHK("irq_oe_n", 1'b1, irq_oe_n)
    `CHK("data_oe_n", 1'b1, data_oe_n)
    // oscillator output is the inverted input one clock later
    repeat (3) begin
      @(posedge clk);
      op = osc_in;
      @(posedge clk);
      `CHK("osc_out", ~op, osc_o)
    end
  endtask

  // status, transmit write, ignored unselected write, control a then b
  task automatic t_port;
    xfer(1'b0, 1'b1, 1'b1, 4'h0);
    `CHK("status", 4'h2, rd)
    `CHK("rd_oe", 1'b0, rd_oe)
    xfer(1'b1, 1'b1, 1'b1, 4'h0);
    `CHK("rd_unsel_oe", 1'b1, rd_oe)
    xfer(1'b0, 1'b0, 1'b0, 4'hB);
    `CHK("tx_digit", 4'hB, tx_digit)
    xfer(1'b1, 1'b0, 1'b0, 4'h5);
    `CHK("tx_unsel", 4'hB, tx_digit)
    `CHK("data_oe_n", 1'b1, data_oe_n)
    xfer(1'b0, 1'b1, 1'b0, 4'hC);
    xfer(1'b0, 1'b1, 1'b0, 4'h2);
  endtask

  // pair acquired, call progress blocks it, then registered
  task automatic t_decode;
    lo_on <= 1'b1;
    hi_on <= 1'b1;
    wait_sig(0, 1'b1, 90000);
    `CHK("gt_early", 1'b0, steer_gt_out)
    xfer(1'b0, 1'b1, 1'b0, 4'h2);
    `CHK("es_cp", 1'b0, early_steer_out)
    xfer(1'b0, 1'b1, 1'b0, 4'hC);
    wait_sig(0, 1'b1, 20);
    wait_sig(1, 1'b1, 200);
    repeat (2) @(posedge clk);
    `CHK("gt_on", 1'b1, steer_gt_out)
    repeat (SETTLE_CYC + 6) @(posedge clk);
    `CHK("irq_low", 1'b0, irq_oe_n)
    xfer(1'b0, 1'b0, 1'b1, 4'h0);
    `CHK("rx_digit", 4'hC, rd)
    xfer(1'b0, 1'b1, 1'b1, 4'h0);
    `CHK("status", 4'hF, rd)
  endtask

  // high tone stops: steering drops, flag and interrupt clear
  task automatic t_loss;
    hi_on <= 1'b0;
    wait_sig(0, 1'b0, 12000);
    @(posedge clk);
    @(posedge clk);
    `CHK("gt_off", 1'b0, steer_gt_out)
    wait_sig(1, 1'b0, 10);
    repeat (4) @(posedge clk);
    `CHK("irq_off", 1'b1, irq_oe_n)
    xfer(1'b0, 1'b1, 1'b1, 4'h0);
    `CHK("status", 4'h2, rd)
  endtask

  // call progress with interrupt on: pin follows the wave, no decoding
  task automatic t_cp;
    xfer(1'b0, 1'b1, 1'b0, 4'h0);  // select bit left set, so this lands in control b
    xfer(1'b0, 1'b1, 1'b0, 4'h6);
    cp_wave <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("cp_high", 1'b1, irq_oe_n)
    cp_wave <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("cp_low", 1'b0, irq_oe_n)
    `CHK("irq_out", 1'b0, irq_out)
    `CHK("es_cp_idle", 1'b0, early_steer_out)
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_port();
    t_decode();
    t_loss();
    t_cp();
    report_and_stop();
  end
endmodule
